// ==== lmpf_core.sv ====
// LED matrix PWM/fade controller: registers, row scan, per-LED duty and slope timing
// Notes on behaviour
// - Row force-on bit holds row switch closed while the matrix enable bit is set, unless its mask bit is set
// - Row mask bit holds row switch open
// - Scan count limits scanned columns
// - Fade-out interval doubles when select set
// - Doubled fade-out also applies in PWM fade
// - Hold extension scales second interval
// - Base interval comes from per-LED slope field
// - Duty gives value over 256 on-time
// - Duty used when PWM select set or, without it, when slope code nonzero (firefly)
// - Sixteen duty registers at consecutive addresses
// - Brightness nibble sets current in equal steps
// - Non-PWM slope code selects firefly period
// - PWM slope code selects fade step time
// - Fade moves duty one count per step
// - One or two columns scale base interval
// - Sixteen brightness registers at consecutive addresses
// - Rows scan one at a time, 255 clocks
// - Mode resolved by fixed priority order
module lmpf_core
    import lmpf_pkg::*;
#(
    parameter int SCAN_DIV = 52       // System clocks per scan clock tick
) (
    input  wire logic        mclk,         // System clock, 125 MHz
    input  wire logic        rst,          // Synchronous reset, active high
    input  wire logic [7:0]  reg_addr,     // Register address
    input  wire logic [7:0]  reg_wdata,    // Write data
    input  wire logic        reg_wr,       // Write strobe
    input  wire logic        reg_rd,       // Read strobe
    output logic      [7:0]  reg_rdata,    // Read data, cycle after strobe
    output logic      [3:0]  row_on,       // High-side switch per row closed
    output logic      [15:0] led_on,       // Sink active per LED (row*4+col)
    output logic      [63:0] led_current   // Brightness code per LED
);
    logic [7:0]   row_ovr_q;
    logic [7:0]   scan_slp_q;
    logic [7:0]   duty_q [NUM_LED];
    logic [7:0]   brt_q  [NUM_LED];
    logic [15:0]  pwm_sel_q;
    logic [7:0]   ctrl_q;
    lmpf_bus_req_t req;
    lmpf_timing_t  tim;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign tim = '{scan_cnt: scan_slp_q[SCAN_CNT_LSB +: 2], fade_dbl: scan_slp_q[FADE_DBL_BIT],
                   low_ext: scan_slp_q[LOW_EXT_LSB +: 2], hold_ext: scan_slp_q[HOLD_EXT_LSB +: 2]};

    // Index decode shared by write and read paths
    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
        return a[7:4] == base[7:4];
    endfunction

    // Register writes; banks decode by upper nibble
    always_ff @(posedge mclk) begin
        if (rst) begin
            row_ovr_q  <= RST_ROW_OVR;
            scan_slp_q <= RST_SCAN_SLP;
            pwm_sel_q  <= '0;
            ctrl_q     <= RST_CTRL;
            for (int i = 0; i < NUM_LED; i++) begin
                brt_q[i] <= RST_BRT;
            end
        end else if (req.wr) begin
            if (req.addr == ADDR_ROW_OVR) row_ovr_q <= req.wdata;
            if (req.addr == ADDR_SCAN_SLP) scan_slp_q <= req.wdata;
            if (req.addr == ADDR_PWM_SEL) pwm_sel_q[7:0] <= req.wdata;
            if (req.addr == ADDR_PWM_SEL_H) pwm_sel_q[15:8] <= req.wdata;
            if (req.addr == ADDR_CTRL) ctrl_q <= req.wdata;
            if (in_bank(req.addr, ADDR_BRT_BASE)) brt_q[req.addr[3:0]] <= req.wdata;
        end
    end

    // Duty registers: software writes, fade engine steps them toward target
    logic [7:0]  target_q [NUM_LED];
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < NUM_LED; i++) begin
                target_q[i] <= RST_DUTY;
            end
        end else if (req.wr && in_bank(req.addr, ADDR_DUTY_BASE)) begin
            target_q[req.addr[3:0]] <= req.wdata;
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (req.rd) begin
            if (req.addr == ADDR_ROW_OVR) reg_rdata <= row_ovr_q;
            else if (req.addr == ADDR_SCAN_SLP) reg_rdata <= scan_slp_q;
            else if (in_bank(req.addr, ADDR_DUTY_BASE)) reg_rdata <= duty_q[req.addr[3:0]];
            else if (in_bank(req.addr, ADDR_BRT_BASE)) reg_rdata <= brt_q[req.addr[3:0]];
            else if (req.addr == ADDR_PWM_SEL) reg_rdata <= pwm_sel_q[7:0];
            else if (req.addr == ADDR_PWM_SEL_H) reg_rdata <= pwm_sel_q[15:8];
            else if (req.addr == ADDR_CTRL) reg_rdata <= ctrl_q;
            else reg_rdata <= '0;
        end
    end

    // Scan clock divider and slot counter
    logic [$clog2(SCAN_DIV)-1:0] div_q;
    logic [7:0]                  slot_q;
    logic [1:0]                  col_q;
    logic                        tick;
    assign tick = (div_q == ($clog2(SCAN_DIV))'(SCAN_DIV - 1));
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_q  <= '0;
            slot_q <= '0;
            col_q  <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
            if (tick) begin
                if (slot_q == 8'(SLOT_CLKS - 1)) begin
                    slot_q <= '0;
                    // Wrap at the last enabled column
                    col_q <= (col_q >= tim.scan_cnt) ? 2'b00 : col_q + 1'b1;
                end else begin
                    slot_q <= slot_q + 1'b1;
                end
            end
        end
    end

    logic active_slot;
    assign active_slot = slot_q < 8'(SLOT_CLKS - GAP_CLKS);  // blank gap between rows

    // Lowering the scan count mid-slot must not finish a slot beyond the new limit
    logic col_in_range;
    assign col_in_range = col_q <= tim.scan_cnt;

    // Row switch drive with mask over force-on
    always_comb begin
        for (int r = 0; r < NUM_ROW; r++) begin
            if (!ctrl_q[CTRL_EN_BIT]) row_on[r] = 1'b0;
            else if (row_ovr_q[ROW_MASK_LSB + r]) row_on[r] = 1'b0;
            else if (row_ovr_q[ROW_FORCE_LSB + r]) row_on[r] = 1'b1;
            else row_on[r] = active_slot && col_in_range && (col_q == 2'(r));
        end
    end

    // Step length in clocks: slope code time scaled by scan setting
    function automatic logic [STEP_W-1:0] step_clks(input logic pwm, input logic [2:0] code,
                                                     input logic [1:0] scan);
        logic [STEP_W-1:0] base;
        base = pwm ? STEP_W'(FADE_STEP_US[code] * CLK_MHZ)
                   : STEP_W'(FIRE_PER_MS[code] * CLK_MHZ * 1000 / 512);
        unique case (scan)
            2'b00: step_clks = base >> 2;
            2'b01: step_clks = base >> 1;
            default: step_clks = base;
        endcase
    endfunction

    // Second-interval (hold at top) scaling of a base step
    function automatic logic [STEP_W-1:0] scale_hold(input logic [STEP_W-1:0] t1,
                                                      input logic [1:0] ext);
        unique case (ext)
            2'b00: scale_hold = t1;
            2'b01: scale_hold = t1 >> 2;
            2'b10: scale_hold = t1 >> 1;
            default: scale_hold = t1 << 1;
        endcase
    endfunction

    // Per-LED fade/firefly engine and duty comparator
    logic [7:0] pwm_cnt_q;
    always_ff @(posedge mclk) begin
        if (rst) pwm_cnt_q <= '0;
        else pwm_cnt_q <= pwm_cnt_q + 1'b1;  // 256-count PWM frame
    end

    genvar g;
    generate
        for (g = 0; g < NUM_LED; g++) begin : g_led
            logic [STEP_W-1:0] tmr_q;
            logic [STEP_W-1:0] t1;
            logic [STEP_W-1:0] t_cur;
            logic              fire_up_q;
            logic              pwm;
            logic [2:0]        code;
            logic              on_pwm;
            assign pwm  = pwm_sel_q[g];
            assign code = brt_q[g][SLOPE_LSB +: 3];
            assign t1   = step_clks(pwm, code, tim.scan_cnt);
            always_comb begin
                if (pwm) begin
                    // Falling steps last twice as long when doubled
                    t_cur = (duty_q[g] > target_q[g] && tim.fade_dbl) ? t1 << 1 : t1;
                end else if (fire_up_q) begin
                    t_cur = t1;
                end else begin
                    t_cur = tim.fade_dbl ? t1 << 1 : t1;
                end
                if (!pwm && duty_q[g] == 8'hff && fire_up_q) t_cur = scale_hold(t1, tim.hold_ext);
                if (t_cur == '0) t_cur = STEP_W'(1);
            end
            always_ff @(posedge mclk) begin
                if (rst) begin
                    duty_q[g]  <= RST_DUTY;
                    tmr_q      <= '0;
                    fire_up_q  <= 1'b1;
                end else if (code == 3'b000) begin
                    // Instant change or constant current
                    // Constant current ignores duty, so keep the written value readable
                    duty_q[g] <= target_q[g];
                    tmr_q     <= '0;
                end else if (tmr_q >= t_cur - 1'b1) begin
                    tmr_q <= '0;
                    if (pwm) begin
                        if (duty_q[g] < target_q[g]) duty_q[g] <= duty_q[g] + 1'b1;
                        else if (duty_q[g] > target_q[g]) duty_q[g] <= duty_q[g] - 1'b1;
                    end else if (fire_up_q) begin
                        if (duty_q[g] == 8'hff) fire_up_q <= 1'b0;  // hold at top
                        else duty_q[g] <= duty_q[g] + 1'b1;
                    end else begin
                        if (duty_q[g] == 8'h00) fire_up_q <= 1'b1;
                        else duty_q[g] <= duty_q[g] - 1'b1;
                    end
                end else begin
                    tmr_q <= tmr_q + 1'b1;
                end
            end
            // Duty 255 still leaves one count off per frame
            assign on_pwm = pwm_cnt_q < duty_q[g];
            always_comb begin
                if (!ctrl_q[CTRL_EN_BIT]) led_on[g] = 1'b0;
                else if (ctrl_q[g % NUM_COL]) led_on[g] = 1'b1;  // column CC override
                else if (pwm) led_on[g] = on_pwm;
                else if (code != 3'b000) led_on[g] = on_pwm;  // firefly
                else led_on[g] = 1'b1;
            end
            // Current code drives a linear DAC, 2 mA per step at reference limit
            assign led_current[g*4 +: 4] = brt_q[g][BRT_LSB +: 4];
        end
    endgenerate
endmodule // lmpf_core

// ==== lmpf_pkg.sv ====
// Package: register map, field layout, reset values and timing for the LED matrix PWM block
package lmpf_pkg;
    localparam int          NUM_LED        = 16;
    localparam int          NUM_ROW        = 4;
    localparam int          NUM_COL        = 4;
    localparam logic [7:0]  ADDR_ROW_OVR   = 8'h0e;
    localparam logic [7:0]  ADDR_SCAN_SLP  = 8'h0f;
    localparam logic [7:0]  ADDR_DUTY_BASE = 8'h10;
    localparam logic [7:0]  ADDR_BRT_BASE  = 8'h20;
    localparam logic [7:0]  ADDR_PWM_SEL   = 8'h30;   // Low byte of PWM select bits
    localparam logic [7:0]  ADDR_PWM_SEL_H = 8'h31;   // High byte of PWM select bits
    localparam logic [7:0]  ADDR_CTRL      = 8'h32;   // Matrix enable and column overrides
    localparam logic [7:0]  RST_ROW_OVR    = 8'h00;
    localparam logic [7:0]  RST_SCAN_SLP   = 8'h60;
    localparam logic [7:0]  RST_DUTY       = 8'h00;
    localparam logic [7:0]  RST_BRT        = 8'h00;
    localparam logic [7:0]  RST_CTRL       = 8'h00;
    localparam int          ROW_FORCE_LSB  = 4;
    localparam int          ROW_MASK_LSB   = 0;
    localparam int          SCAN_CNT_LSB   = 5;
    localparam int          FADE_DBL_BIT   = 4;
    localparam int          LOW_EXT_LSB    = 2;
    localparam int          HOLD_EXT_LSB   = 0;
    localparam int          BRT_LSB        = 4;
    localparam int          SLOPE_LSB      = 0;
    localparam int          CTRL_EN_BIT    = 7;
    // Scan slot: 255 clocks of the scan clock, last 4 blank
    localparam int          SLOT_CLKS      = 255;
    localparam int          GAP_CLKS       = 4;
    localparam int          DUTY_FULL      = 256;
    // Fade step times in microseconds, firefly periods in milliseconds, indexed by slope code
    localparam int          CLK_MHZ        = 125;
    localparam int          FADE_STEP_US [8] = '{0, 1720, 3440, 6890, 10340, 13790, 17300, 20700};
    localparam int          FIRE_PER_MS  [8] = '{0, 220, 440, 880, 1320, 1760, 2200, 2640};
    localparam int          STEP_W         = 40;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lmpf_bus_req_t;

    typedef struct packed {
        logic [1:0] scan_cnt;
        logic       fade_dbl;
        logic [1:0] low_ext;
        logic [1:0] hold_ext;
    } lmpf_timing_t;

    typedef enum logic [1:0] {
        LMPF_FADE_IDLE = 2'b00,
        LMPF_FADE_UP   = 2'b01,
        LMPF_FADE_DOWN = 2'b10
    } lmpf_fade_t;
endpackage : lmpf_pkg

// ==== lmpf_core_sva.sv ====
// Checker: port-level properties of the LED matrix PWM block
module lmpf_core_sva
    import lmpf_pkg::*;
#(
    parameter int SCAN_DIV = 52          // Scan clock divider, passed through
) (
    input wire logic        mclk,        // Clock
    input wire logic        rst,         // Sync reset
    input wire logic [7:0]  reg_addr,    // Address
    input wire logic [7:0]  reg_wdata,   // Write data
    input wire logic        reg_wr,      // Write strobe
    input wire logic        reg_rd,      // Read strobe
    input wire logic [7:0]  reg_rdata,   // Read data
    input wire logic [3:0]  row_on,      // Row switches
    input wire logic [15:0] led_on,      // Sinks
    input wire logic [63:0] led_current  // Brightness codes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ovr_q;
    logic [7:0] scan_q;
    logic [7:0] ctl_q;
    logic       en;
    // Mirror of the steering registers, updated on the same edge as the block's own
    always_ff @(posedge mclk) begin
        if (rst) begin
            ovr_q  <= RST_ROW_OVR;
            scan_q <= RST_SCAN_SLP;
            ctl_q  <= RST_CTRL;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_ROW_OVR) ovr_q <= reg_wdata;
            if (reg_addr == ADDR_SCAN_SLP) scan_q <= reg_wdata;
            if (reg_addr == ADDR_CTRL) ctl_q <= reg_wdata;
        end
    end
    // Column overrides act only on the sinks; rows are still judged only without them
    assign en = ctl_q[CTRL_EN_BIT] && ctl_q[3:0] == 4'h0;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_force_closed: assert property (en |-> (row_on & ovr_q[7:4] & ~ovr_q[3:0]) ==
        (ovr_q[7:4] & ~ovr_q[3:0])) else $error("forced row switch open");
    a_mask_open: assert property (en |-> (row_on & ovr_q[3:0]) == 4'h0)
        else $error("masked row switch closed");
    a_matrix_off: assert property (!ctl_q[CTRL_EN_BIT] |-> row_on == 4'h0 && led_on == 16'h0)
        else $error("matrix off but outputs active");
    a_one_row: assert property (en && ovr_q == 8'h00 |-> $onehot0(row_on))
        else $error("more than one row switch closed");
    a_scan_first: assert property (en && ovr_q == 8'h00 && scan_q[6:5] == 2'b00
        |-> row_on[3:1] == 3'b000) else $error("row beyond scan count active");
    a_read_scan: assert property (reg_rd && reg_addr == ADDR_SCAN_SLP
        |=> reg_rdata == $past(scan_q)) else $error("scan timing readback wrong");
    a_read_ovr: assert property (reg_rd && reg_addr == ADDR_ROW_OVR
        |=> reg_rdata == $past(ovr_q)) else $error("row override readback wrong");
    a_read_unmapped: assert property (reg_rd && reg_addr > ADDR_CTRL |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_current_hold: assert property (!(reg_wr && reg_addr[7:4] == 4'h2)
        |=> $stable(led_current)) else $error("current code moved without write");
endmodule // lmpf_core_sva

// ==== lmpf_matrix_model.sv ====
// Partner model: 4x4 LED matrix lit by row switches and column sinks
module lmpf_matrix_model (
    input wire logic [3:0]  row_on,      // Row high-side switches
    input wire logic [15:0] led_on,      // Column sinks per LED
    input wire logic [63:0] led_current, // Current codes
    output logic     [15:0] lit          // LED conducting
);
    timeunit 1ns;
    timeprecision 1ps;
    // A diode conducts only with its row closed, its sink on and a nonzero current
    always_comb begin
        for (int g = 0; g < 16; g++) begin
            lit[g] = row_on[g / 4] && led_on[g] && (led_current[g*4 +: 4] != 4'h0);
        end
    end
endmodule // lmpf_matrix_model

// ==== tb_lmpf.sv ====
// Testbench: register map, row control, scan limit and PWM duty checks
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb
    import lmpf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [3:0]  row_on;
    logic [15:0] led_on;
    logic [15:0] lit;
    logic [63:0] led_current;
    logic [3:0]  seen;
    logic [7:0]  d;
    int          error_cnt = 0;
    int          check_count = 0;
    int          lit_n;
    int          c;
    localparam int FRAME = NUM_ROW * SLOT_CLKS * 2;  // One full scan at divider 2
    always #4 mclk = ~mclk;
    lmpf_core #(.SCAN_DIV(2)) uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .row_on(row_on), .led_on(led_on), .led_current(led_current));
    lmpf_matrix_model mtx (.row_on(row_on), .led_on(led_on), .led_current(led_current),
        .lit(lit));
    // Bus cycles: waiting for the edge first keeps back-to-back strobes from colliding
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
    // Counts lit cycles of the first LED and which rows closed, sampled mid-cycle
    task automatic watch(input int n);
        lit_n = 0;
        seen = 4'h0;
        repeat (n) begin
            @(negedge mclk);
            lit_n += int'(lit[0]);
            seen |= row_on;
        end
    endtask
    task automatic t_reset;
        rd(ADDR_ROW_OVR);  `CHK(d, RST_ROW_OVR)
        rd(ADDR_SCAN_SLP); `CHK(d, RST_SCAN_SLP)
        rd(8'h1f);         `CHK(d, RST_DUTY)
        rd(8'h2f);         `CHK(d, RST_BRT)
        rd(8'h40);         `CHK(d, 8'h00)
        $display("reset values done");
    endtask
    task automatic t_regs;
        wr(ADDR_SCAN_SLP, 8'h7f);
        rd(ADDR_SCAN_SLP); `CHK(d, 8'h7f)
        for (int g = 0; g < NUM_LED; g++) begin
            wr(ADDR_BRT_BASE + 8'(g), {g[3:0], 4'h0});
            wr(ADDR_DUTY_BASE + 8'(g), ~8'(g));
        end
        for (int g = 0; g < NUM_LED; g++) begin
            rd(ADDR_BRT_BASE + 8'(g));  `CHK(d, {g[3:0], 4'h0})
            `CHK(led_current[g*4 +: 4], g[3:0])
            rd(ADDR_DUTY_BASE + 8'(g)); `CHK(d, ~8'(g))
        end
        $display("register map done");
    endtask
    task automatic t_rows;
        wr(ADDR_CTRL, 8'h80);
        wr(ADDR_ROW_OVR, 8'hf0);
        watch(20); `CHK(row_on, 4'hf)
        wr(ADDR_ROW_OVR, 8'hf3);
        watch(20); `CHK(seen, 4'hc)
        $display("row override done");
    endtask
    // Every scan count code, each watched over one whole frame
    task automatic t_scan;
        wr(ADDR_ROW_OVR, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_SCAN_SLP, {1'b0, s[1:0], 5'h00});
            watch(FRAME); `CHK(seen, 4'((1 << (s + 1)) - 1))
        end
        $display("scan count done");
    endtask
    task automatic t_pwm;
        wr(ADDR_BRT_BASE, 8'hf0);
        wr(ADDR_DUTY_BASE, 8'h00);
        watch(FRAME); c = lit_n; `CHK(c > 0, 1'b1)
        wr(ADDR_PWM_SEL, 8'h01);
        watch(FRAME); `CHK(lit_n, 0)
        wr(ADDR_DUTY_BASE, 8'h80);
        watch(FRAME); `CHK(lit_n > 0 && lit_n < c, 1'b1)
        wr(ADDR_DUTY_BASE, 8'h00);
        wr(ADDR_BRT_BASE, 8'hf1);
        wr(ADDR_DUTY_BASE, 8'hff);
        rd(ADDR_DUTY_BASE); `CHK(d[7:1], 7'h00)
        $display("pwm duty and fade done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_regs;
        t_rows;
        t_scan;
        t_pwm;
        complete_run;
    end
endmodule // tb
bind lmpf_core lmpf_core_sva #(.SCAN_DIV(SCAN_DIV)) u_sva (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .row_on(row_on), .led_on(led_on), .led_current(led_current));
